// ### pcx_core_model.sv
// Core-side partner: acknowledges raised vector requests.
// Assumes vectorReq settles before each rising clk edge.
`timescale 1ns/1ps
module pcx_core_model
  import pcx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ackEn,
  input wire pcx_src_s vectorReq,
  output pcx_src_s vectorAck
);
  // ----
  // Ack
  // ----
  // Gap after each pulse, so a held request is acked only every other cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vectorAck <= '0;
    end else begin
      vectorAck <= (ackEn ? vectorReq : '0) & ~vectorAck;
    end
  end
endmodule // pcx_core_model

// ### pcx_int_flags.sv
// Flag, enable and mask logic for two external interrupt pins and three pin-change groups.
// Assumes an APB master on clk, the core giving its global interrupt bit and one-cycle vector acks.
//
// Summary of operation
// - Edge or change on external pin sets that pin's flag, bit 1 or 0.
// - External vector requested only with flag, global bit and pin enable set; here level-sense mode requests while the pin is low, with no flag.
// - Executing a source's service routine clears its flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - A pin in level-sense mode keeps its flag at zero.
// - Unused upper bits of flag and group registers read zero.
// - Group 2 enable with global bit enables pins 23..16 on own vector.
// - Group 1 enable with global bit enables pins 14..8 on own vector.
// - Group 0 enable with global bit enables pins 7..0 on own vector.
// - A change on any group pin whose mask bit is set sets that group's flag.
// - Group vector requested only with flag, group enable and global bit.
// - Group 2 mask bits 7:0 let pins 23..16 contribute when set.
// - Group 1 mask bits 6:0 serve pins 14..8; bit 7 reads zero.
// - Group 0 mask bits 7:0 serve pins 7..0.
// - Pin changes detected without the I/O clock, usable for deep-sleep wake; here detection is clocked, so a stopped clk misses changes.
// - Interrupts fire even when pins are driven as outputs.
// - Sense 00 low level, 01 any change, 10 falling, 11 rising.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps

module pcx_int_flags
  import pcx_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PCX_NUM_EXT-1:0] extPin,
  input wire logic [PCX_NUM_PINS-1:0] changeWatchedPin,
  input wire logic globalIntEnable,
  input wire pcx_src_s vectorAck,
  output pcx_src_s vectorReq
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W outside the range the register map can use");
  end

  // Group slices below assume eight pins per group with pin 15 absent.
  if (PCX_NUM_PINS != 8 * PCX_NUM_GRP || PCX_GRP1_MASK_W != 7) begin : g_map_chk
    $error("pin map does not match the group slicing");
  end

  if (PCX_NUM_EXT != 2) begin : g_ext_chk
    $error("sense register holds exactly two external pins");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins are sampled whatever their direction, so software can self-trigger.
  logic [PCX_NUM_EXT-1:0] extMeta_q, extSync_q, extPrev_q;
  logic [PCX_NUM_PINS-1:0] pcMeta_q, pcSync_q, pcPrev_q;

  // Pulses shorter than one clock may be missed.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extMeta_q <= '0;
      extSync_q <= '0;
      extPrev_q <= '0;
    end else begin
      extMeta_q <= extPin;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcMeta_q <= '0;
      pcSync_q <= '0;
      pcPrev_q <= '0;
    end else begin
      pcMeta_q <= changeWatchedPin;
      pcSync_q <= pcMeta_q;
      pcPrev_q <= pcSync_q;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [7:0] extPinFlagsQ;
  logic [2:0] pinChangeFlags_q;
  logic [1:0] extPinFlags_q;
  logic [2:0] groupEnables_q;
  logic [7:0] maskGroup0_q, maskGroup2_q;
  logic [PCX_GRP1_MASK_W-1:0] maskGroup1_q;
  logic [1:0] extEnableMask_q;
  logic [3:0] extSense_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [9:0] regIdx;
  logic addrOk;
  logic wrAcc;
  logic [7:0] rdByte;
  logic rdHit;

  assign regIdx = paddr[11:2];
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:11] == '0);
  assign wrAcc = psel && penable && pwrite && addrOk;
  assign extPinFlagsQ = {6'h00, extPinFlags_q};

  function automatic logic isReg(input logic [9:0] idx, input logic [9:0] want);
    isReg = (idx == want);
  endfunction

  always_comb begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    case (regIdx)
      PCX_IDX_PIN_CHANGE_FLAGS: rdByte = {5'h00, pinChangeFlags_q};
      PCX_IDX_MASK_GROUP0: rdByte = maskGroup0_q;
      PCX_IDX_MASK_GROUP2: rdByte = maskGroup2_q;
      PCX_IDX_EXT_PIN_FLAGS: rdByte = extPinFlagsQ;
      PCX_IDX_GROUP_ENABLES: rdByte = {5'h00, groupEnables_q};
      PCX_IDX_MASK_GROUP1: rdByte = {1'b0, maskGroup1_q};
      PCX_IDX_EXT_ENABLE_MASK: rdByte = {6'h00, extEnableMask_q};
      PCX_IDX_EXT_SENSE: rdByte = {4'h0, extSense_q};
      default: rdHit = 1'b0;
    endcase
  end

  // Read data captured in setup so the access phase answers with zero wait.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= (rdHit && addrOk && !pwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
    end
  end

  // Error flag follows the same setup capture as the read data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !(rdHit && addrOk);
    end
  end

  assign prdata = prdata_q;
  // Zero wait states: every access phase completes at once.
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Unused bits are not stored, so they always read back as zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      groupEnables_q <= PCX_RST_GRP_FLAGS;
    end else if (wrAcc && isReg(regIdx, PCX_IDX_GROUP_ENABLES)) begin
      groupEnables_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskGroup0_q <= PCX_RST_BYTE;
    end else if (wrAcc && isReg(regIdx, PCX_IDX_MASK_GROUP0)) begin
      maskGroup0_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskGroup1_q <= PCX_RST_BYTE[PCX_GRP1_MASK_W-1:0];
    end else if (wrAcc && isReg(regIdx, PCX_IDX_MASK_GROUP1)) begin
      maskGroup1_q <= pwdata[PCX_GRP1_MASK_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskGroup2_q <= PCX_RST_BYTE;
    end else if (wrAcc && isReg(regIdx, PCX_IDX_MASK_GROUP2)) begin
      maskGroup2_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extEnableMask_q <= PCX_RST_EXT_FLAGS;
    end else if (wrAcc && isReg(regIdx, PCX_IDX_EXT_ENABLE_MASK)) begin
      extEnableMask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extSense_q <= PCX_RST_BYTE[3:0];
    end else if (wrAcc && isReg(regIdx, PCX_IDX_EXT_SENSE)) begin
      extSense_q <= pwdata[3:0];
    end
  end

  // ----------------------------------------
  // External pin events
  // ----------------------------------------
  logic [1:0] extEvent, extLevelMode, extLevelReq;

  for (genvar i = 0; i < PCX_NUM_EXT; i++) begin : g_ext
    logic [1:0] sense;
    logic rise, fall;
    assign sense = extSense_q[2*i+1:2*i];
    assign rise = extSync_q[i] && !extPrev_q[i];
    assign fall = !extSync_q[i] && extPrev_q[i];
    logic evt;
    // Edges come from the synced pair, so a sense change never fakes one.
    always_comb begin
      evt = 1'b0;
      case (sense)
        PCX_SENSE_ANY: evt = rise || fall;
        PCX_SENSE_FALL: evt = fall;
        PCX_SENSE_RISE: evt = rise;
        default: evt = 1'b0;
      endcase
    end
    assign extEvent[i] = evt;
    assign extLevelMode[i] = (sense == PCX_SENSE_LOW);
    // Level mode requests for as long as the pin stays low; no flag involved.
    assign extLevelReq[i] = extLevelMode[i] && !extSync_q[i];
  end

  // ----------------------------------------
  // Flags: set beats clear
  // ----------------------------------------
  logic [2:0] grpEvent;
  logic [1:0] extWrClr;
  logic [2:0] grpWrClr;

  logic [7:0] grpMask [PCX_NUM_GRP];
  // Group 1 has seven pins; its padded zero bit drops pin 15.
  assign grpMask[0] = maskGroup0_q;
  assign grpMask[1] = {1'b0, maskGroup1_q};
  assign grpMask[2] = maskGroup2_q;

  // Detection is clocked here, so a stopped clock misses changes; sleep wake needs a free clk.
  for (genvar g = 0; g < PCX_NUM_GRP; g++) begin : g_grp
    logic [7:0] delta;
    assign delta = pcSync_q[8*g+7:8*g] ^ pcPrev_q[8*g+7:8*g];
    assign grpEvent[g] = |(delta & grpMask[g]);
  end

  assign extWrClr = (wrAcc && isReg(regIdx, PCX_IDX_EXT_PIN_FLAGS)) ? pwdata[1:0] : 2'h0;
  assign grpWrClr = (wrAcc && isReg(regIdx, PCX_IDX_PIN_CHANGE_FLAGS)) ? pwdata[2:0] : 3'h0;

  logic [1:0] extPinFlags_d;
  logic [2:0] pinChangeFlags_d;

  always_comb begin
    extPinFlags_d = extPinFlags_q & ~extWrClr & ~vectorAck.ext;
    extPinFlags_d = (extPinFlags_d | extEvent) & ~extLevelMode;
  end

  always_comb begin
    pinChangeFlags_d = pinChangeFlags_q & ~grpWrClr & ~vectorAck.grp;
    pinChangeFlags_d = pinChangeFlags_d | grpEvent;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extPinFlags_q <= PCX_RST_EXT_FLAGS;
    end else begin
      extPinFlags_q <= extPinFlags_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinChangeFlags_q <= PCX_RST_GRP_FLAGS;
    end else begin
      pinChangeFlags_q <= pinChangeFlags_d;
    end
  end

  // ----------------------------------------
  // Vector requests
  // ----------------------------------------
  logic [1:0] extPending;
  assign extPending = extPinFlags_q | extLevelReq;
  assign vectorReq.ext = extPending & extEnableMask_q & {2{globalIntEnable}};
  assign vectorReq.grp = pinChangeFlags_q & groupEnables_q & {3{globalIntEnable}};

endmodule // pcx_int_flags

// ### pcx_int_flags_checker.sv
// Port assertions for the interrupt flag block.
// Assumes binding to pcx_int_flags; one clock domain.
`timescale 1ns/1ps
module pcx_int_flags_checker
  import pcx_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PCX_NUM_PINS-1:0] changeWatchedPin,
  input wire logic globalIntEnable,
  input wire pcx_src_s vectorAck,
  input wire pcx_src_s vectorReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rdA;
  assign rdA = psel && penable && !pwrite;
  // Pins quiet long enough that no set can race the ack
  sequence pinsQuiet; $stable(changeWatchedPin) [*5]; endsequence
  sequence grpAck; pinsQuiet ##0 (vectorAck.grp != '0); endsequence
  chk_gie_gates_req: assert property (!globalIntEnable |-> vectorReq == '0)
    else $error("vector request without global bit");
  chk_ack_clears_grp: assert property (grpAck |=> (vectorReq.grp & $past(vectorAck.grp)) == '0)
    else $error("group request survives ack");
  chk_ext_upper_zero: assert property (rdA && paddr == {PCX_IDX_EXT_PIN_FLAGS, 2'b00} |-> prdata[7:2] == '0)
    else $error("external flag upper bits set");
  chk_grp_upper_zero: assert property (rdA && (paddr == {PCX_IDX_PIN_CHANGE_FLAGS, 2'b00}
    || paddr == {PCX_IDX_GROUP_ENABLES, 2'b00}) |-> prdata[7:3] == '0)
    else $error("group register upper bits set");
  chk_mask1_top_zero: assert property (rdA && paddr == {PCX_IDX_MASK_GROUP1, 2'b00} |-> !prdata[7])
    else $error("group 1 mask bit 7 set");
  chk_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_err_data_zero: assert property (rdA && pslverr |-> prdata == '0)
    else $error("refused read returns data");
  chk_rdata_byte_only: assert property (rdA |-> prdata[31:8] == '0)
    else $error("read data above byte");
  chk_ready_access: assert property (psel && !penable |=> pready)
    else $error("access phase not ready");
endmodule // pcx_int_flags_checker
bind pcx_int_flags pcx_int_flags_checker #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .changeWatchedPin(changeWatchedPin), .globalIntEnable(globalIntEnable), .vectorAck(vectorAck),
  .vectorReq(vectorReq));

// ### pcx_int_flags_tb_top.sv
// Self-checking bench for the interrupt flag block.
// Assumes the core model acks vectors and the checker is bound.
`timescale 1ns/1ps
module pcx_int_flags_tb_top import pcx_pkg::*;;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, globalIntEnable = 1, ackEn = 0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr;
  logic [1:0] extPin = '0;
  logic [23:0] changeWatchedPin = '0;
  pcx_src_s vectorAck, vectorReq;
  int err_total = 0, comparisons = 0;
  always #25 clk = ~clk;
  pcx_int_flags i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extPin(extPin),
    .changeWatchedPin(changeWatchedPin), .globalIntEnable(globalIntEnable), .vectorAck(vectorAck),
    .vectorReq(vectorReq));
  pcx_core_model i_core (.clk(clk), .rst(rst), .ackEn(ackEn), .vectorReq(vectorReq), .vectorAck(vectorAck));
  // ----
  // Tasks
  // ----
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk(0, 1);
      tally_and_finish();
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    apb(0, idx, 0);
    chk(rd, exp);
  endtask
  task automatic flip(input int i);
    @(posedge clk);
    changeWatchedPin[i] <= ~changeWatchedPin[i];
    repeat (6) @(posedge clk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    logic [9:0] ix [8] = '{10'h03B, 10'h06B, 10'h06D, 10'h070, 10'h071, 10'h072, 10'h073, 10'h074};
    foreach (ix[k]) rdc(ix[k], 0);
    apb(0, 10'h000, 0);
    chk({31'h0, er}, 1);
    apb(1, PCX_IDX_MASK_GROUP0, 32'hFF);
    apb(1, PCX_IDX_MASK_GROUP2, 32'hFF);
    apb(1, PCX_IDX_MASK_GROUP1, 32'hFF);
    apb(1, PCX_IDX_GROUP_ENABLES, 32'hFF);
    rdc(PCX_IDX_MASK_GROUP0, 32'hFF);
    rdc(PCX_IDX_MASK_GROUP2, 32'hFF);
    rdc(PCX_IDX_MASK_GROUP1, 32'h7F);
    rdc(PCX_IDX_GROUP_ENABLES, 32'h07);
    foreach (ix[k]) if (k == 1 || k == 2 || k == 5) apb(1, ix[k], 32'h01);
  endtask
  task automatic t_groups;
    for (int g = 0; g < 3; g++) begin
      flip(8 * g + 1);
      rdc(PCX_IDX_PIN_CHANGE_FLAGS, 0);
      flip(8 * g);
      chk(vectorReq.grp, 1 << g);
      apb(1, PCX_IDX_GROUP_ENABLES, 32'h07 ^ (32'h1 << g));
      @(posedge clk);
      chk(vectorReq.grp, 0);
      apb(1, PCX_IDX_GROUP_ENABLES, 32'h07);
      apb(1, PCX_IDX_PIN_CHANGE_FLAGS, 0);
      rdc(PCX_IDX_PIN_CHANGE_FLAGS, 1 << g);
      apb(1, PCX_IDX_PIN_CHANGE_FLAGS, 1 << g);
      rdc(PCX_IDX_PIN_CHANGE_FLAGS, 0);
      globalIntEnable <= 0;
      flip(8 * g);
      chk(vectorReq.grp, 0);
      globalIntEnable <= 1; ackEn <= 1;
      repeat (4) @(posedge clk);
      ackEn <= 0;
      rdc(PCX_IDX_PIN_CHANGE_FLAGS, 0);
    end
  endtask
  task automatic t_ext;
    logic [1:0] sv [4] = '{PCX_SENSE_ANY, PCX_SENSE_FALL, PCX_SENSE_RISE, PCX_SENSE_LOW};
    logic [31:0] want;
    apb(1, PCX_IDX_EXT_ENABLE_MASK, 3);
    for (int p = 0; p < 2; p++) foreach (sv[k]) begin
      apb(1, PCX_IDX_EXT_SENSE, 32'(sv[k]) << (2 * p));
      apb(1, PCX_IDX_EXT_PIN_FLAGS, 3);
      @(posedge clk) extPin[p] <= 1;
      repeat (6) @(posedge clk);
      want = 32'(sv[k] == PCX_SENSE_ANY || sv[k] == PCX_SENSE_RISE) << p;
      rdc(PCX_IDX_EXT_PIN_FLAGS, want);
      chk(vectorReq.ext, want | (32'h1 << (1 - p)));
      apb(1, PCX_IDX_EXT_PIN_FLAGS, 3);
      @(posedge clk) extPin[p] <= 0;
      repeat (6) @(posedge clk);
      want = 32'(sv[k] == PCX_SENSE_ANY || sv[k] == PCX_SENSE_FALL) << p;
      rdc(PCX_IDX_EXT_PIN_FLAGS, want);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_regs();
    t_groups();
    t_ext();
    tally_and_finish();
  end
endmodule // pcx_int_flags_tb_top

// ### pcx_pkg.sv
// Shared constants and carrier types for the pin-change and external interrupt flag block.
// Assumes an APB slave with 32-bit data; register indices are word indices (byte address = 4 * index).
package pcx_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [9:0] PCX_IDX_PIN_CHANGE_FLAGS = 10'h03B;
  localparam logic [9:0] PCX_IDX_MASK_GROUP0 = 10'h06B;
  localparam logic [9:0] PCX_IDX_MASK_GROUP2 = 10'h06D;
  localparam logic [9:0] PCX_IDX_EXT_PIN_FLAGS = 10'h070;
  localparam logic [9:0] PCX_IDX_GROUP_ENABLES = 10'h071;
  localparam logic [9:0] PCX_IDX_MASK_GROUP1 = 10'h072;
  localparam logic [9:0] PCX_IDX_EXT_ENABLE_MASK = 10'h073;
  localparam logic [9:0] PCX_IDX_EXT_SENSE = 10'h074;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] PCX_RST_BYTE = 8'h00;
  localparam logic [1:0] PCX_RST_EXT_FLAGS = 2'h0;
  localparam logic [2:0] PCX_RST_GRP_FLAGS = 3'h0;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PCX_NUM_EXT = 2;
  localparam int PCX_NUM_GRP = 3;
  localparam int PCX_NUM_PINS = 24;
  localparam int PCX_GRP1_MASK_W = 7;

  // Sense encodings per external pin
  localparam logic [1:0] PCX_SENSE_LOW = 2'h0;
  localparam logic [1:0] PCX_SENSE_ANY = 2'h1;
  localparam logic [1:0] PCX_SENSE_FALL = 2'h2;
  localparam logic [1:0] PCX_SENSE_RISE = 2'h3;

  // One bit per interrupt source, used for vector requests and acknowledges
  typedef struct packed {
    logic [PCX_NUM_GRP-1:0] grp;
    logic [PCX_NUM_EXT-1:0] ext;
  } pcx_src_s;

endpackage
